// file: inc/line_port_consts.vh
// register offsets, field positions, reset values and clock figures for the line port
// register bank; assumes a 16-bit dsp address space and an 8-bit host address space
`ifndef LINE_PORT_CONSTS_VH
`define LINE_PORT_CONSTS_VH

`define OFS_CHANNEL_IRQ_ENABLE 16'hd002
`define OFS_FRAME_EVENT_STATUS 16'hd003
`define OFS_STAT_COUNT_VALUE 16'hd004
`define OFS_STAT_COUNT_LIMIT 16'hd005
`define OFS_LINE_CLOCK3_CONTROL 16'hd08d
`define OFS_HOST_INTERFACE_CONFIG 16'hd148
`define OFS_PIN_SHARING_CONTROL 16'hd14a
`define HOST_OFS_INTERFACE_CONFIG 8'h48

`define LCLK_RATE_LSB 0
`define LCLK_RATE_MSB 1
`define LCLK_OUT_EN_BIT 2
`define BACKPLANE_REUSE_BIT 0
`define PCM02_REUSE_BIT 1
`define PCM13_REUSE_BIT 2
`define TABLE_WRITE_EN_BIT 8
`define FRAME_RATE_SEL_BIT 9
`define IRQ_ENABLE_BIT 0
`define BOTH_SYNC_BIT 0
`define BACKPLANE_SYNC_BIT 1
`define PCM_SYNC_BIT 2
`define CFG_DMA_BIT 0
`define CFG_FLYBY_BIT 1
`define CFG_PEC_BIT 2
`define CFG_ACK_MODE_BIT 3
`define CFG_IRQ_EN_BIT 4
`define CFG_IRQ_PUSHPULL_BIT 5
`define CFG_IRQ_POL_BIT 6
`define CFG_DRQ_POL_BIT 7
`define CFG_MODE_BIT 8

`define RST_LINE_CLOCK3 3'h0
`define RST_PIN_SHARING 3'h0
`define RST_IRQ_ENABLE 1'h0
`define RST_FRAME_EVENTS 3'h0
`define RST_STAT_LIMIT 8'h00
`define RST_HOST_CONFIG 8'h00
`define RST_DSP_STATUS_TWO 2'h0

// cycles after internal release before the mode strap level is trusted
`define MODE_SETTLE_COUNT 3'h5

// clock figures in khz; the nco increment is derived from these
`define MCLK_KHZ 32'd200000
`define LCLK_BASE_KHZ 32'd2048

`endif

// file: design/sync_rise.v
// three-flop synchroniser for one pin with a filtered level and a rising-edge pulse;
// assumes the pin is asynchronous to clk and held for at least three clk cycles
module sync_rise (
  input wire clk,
  input wire rst_n,
  input wire pin,
  output reg level,
  output reg rise
);
  reg s1_r;
  reg s2_r;
  reg s3_r;

  // s1_r feeds only s2_r; a change counts once s2_r and s3_r agree
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      level <= 1'b0;
      rise <= 1'b0;
    end
    else
    begin
      s1_r <= pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r)
        level <= s3_r;
      rise <= (s2_r == s3_r) && s3_r && !level;
    end
  end
endmodule // sync_rise

// file: design/line_clock_nco.v
// phase accumulator that makes the line clock from mclk at one of four rates;
// assumes mclk at MCLK_KHZ; edges jitter by one mclk period since rates do not divide
`include "line_port_consts.vh"
module line_clock_nco (
  input wire clk,
  input wire rst_n,
  input wire run,
  input wire [1:0] rate,
  output reg clk_out
);
  wire [31:0] base_khz;
  wire [63:0] quo;
  reg [31:0] acc_r;

  assign base_khz = `LCLK_BASE_KHZ << rate;
  assign quo = ({32'h0, base_khz} << 32) / {32'h0, `MCLK_KHZ};

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      acc_r <= 32'h0;
      clk_out <= 1'b0;
    end
    else
    begin
      // held at zero while stopped so the first output period is whole
      acc_r <= run ? acc_r + quo[31:0] : 32'h0;
      clk_out <= run & acc_r[31];
    end
  end
endmodule // line_clock_nco

// file: design/line_port_regs.v
// control and status registers of the line interface controller: line clock three,
// pin sharing, dsp status two, channel irq mask, frame events, statistics, host config;
// assumes single-cycle dsp and host strobes synchronous to mclk and frame pins async
`include "line_port_consts.vh"

module line_port_regs (
  input wire mclk,
  input wire rst_b,
  input wire [15:0] dsp_addr,
  input wire dsp_wr,
  input wire dsp_rd,
  input wire [15:0] dsp_wdata,
  output reg [15:0] dsp_rdata,
  input wire dsp_status_two_wr,
  input wire [15:0] dsp_status_two_wdata,
  input wire [7:0] host_addr,
  input wire host_wr,
  input wire host_rd,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  input wire line_clock_pin_three_in,
  output reg line_clock_pin_three_out,
  output reg line_clock_pin_three_oe_b,
  output reg line_clock_seen,
  output reg backplane_pin_reuse,
  output reg pcm02_pin_reuse,
  output reg pcm13_pin_reuse,
  output reg frame_rate_select,
  output reg table_write_enable,
  input wire table_wr_req,
  input wire [1:0] table_sel,
  output reg [2:0] table_wr_grant,
  input wire serial_irq_req,
  output reg serial_irq_out,
  input wire pcm_frame_sync_pin,
  input wire backplane_frame_sync_pin,
  input wire stat_event,
  output reg stat_count_at_limit,
  output reg dma_enable,
  output reg flyby_select,
  output reg peripheral_event_transfer,
  input wire interrupt_ack_pin,
  output reg vector_drive,
  input wire host_irq_req,
  output reg host_interrupt_pin_out,
  output reg host_interrupt_pin_oe_b,
  input wire dma_req_rx,
  input wire dma_req_tx,
  output reg [1:0] dma_request_pins,
  input wire mode_pin
);

  ////////////////////////////////////////////////////////////////////////////////////
  // reset release and pin synchronisers

  reg rst_meta_r;
  reg rst_n_r;
  wire pcm_fs_rise;
  wire bp_fs_rise;
  wire lclk_in_level;
  wire ack_level;
  wire ack_rise;
  wire mode_level;
  wire nco_clk;

  always @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rst_meta_r <= 1'b0;
      rst_n_r <= 1'b0;
    end
    else
    begin
      rst_meta_r <= 1'b1;
      rst_n_r <= rst_meta_r;
    end
  end

  sync_rise u_pcm_fs (
    .clk(mclk),
    .rst_n(rst_n_r),
    .pin(pcm_frame_sync_pin),
    .level(),
    .rise(pcm_fs_rise)
  );

  sync_rise u_bp_fs (
    .clk(mclk),
    .rst_n(rst_n_r),
    .pin(backplane_frame_sync_pin),
    .level(),
    .rise(bp_fs_rise)
  );

  sync_rise u_lclk_in (
    .clk(mclk),
    .rst_n(rst_n_r),
    .pin(line_clock_pin_three_in),
    .level(lclk_in_level),
    .rise()
  );

  sync_rise u_ack (
    .clk(mclk),
    .rst_n(rst_n_r),
    .pin(interrupt_ack_pin),
    .level(ack_level),
    .rise(ack_rise)
  );

  sync_rise u_mode (
    .clk(mclk),
    .rst_n(rst_n_r),
    .pin(mode_pin),
    .level(mode_level),
    .rise()
  );

  ////////////////////////////////////////////////////////////////////////////////////
  // register storage and decode

  reg [2:0] line_clock_pin_three_ctrl_r;
  reg [2:0] pin_share_r;
  reg [1:0] status_two_r;
  reg irq_enable_bit_r;
  reg [2:0] events_r;
  reg [2:0] events_nxt;
  reg [7:0] stat_count_r;
  reg [7:0] stat_count_nxt;
  reg stat_read_seen_r;
  reg [7:0] stat_limit_r;
  reg [7:0] host_cfg_r;
  reg mode_caught_r;
  reg [2:0] mode_wait_r;
  reg [1:0] ack_count_r;
  reg [15:0] rdata_nxt;
  wire wr_line_clock_pin_three;
  wire wr_share;
  wire wr_irq_en;
  wire wr_count;
  wire wr_limit;
  wire rd_events;
  wire rd_count;
  wire irq_level;

  assign wr_line_clock_pin_three = dsp_wr && (dsp_addr == `OFS_LINE_CLOCK3_CONTROL);
  assign wr_share = dsp_wr && (dsp_addr == `OFS_PIN_SHARING_CONTROL);
  assign wr_irq_en = dsp_wr && (dsp_addr == `OFS_CHANNEL_IRQ_ENABLE);
  assign wr_count = dsp_wr && (dsp_addr == `OFS_STAT_COUNT_VALUE);
  assign wr_limit = dsp_wr && (dsp_addr == `OFS_STAT_COUNT_LIMIT);
  assign rd_events = dsp_rd && (dsp_addr == `OFS_FRAME_EVENT_STATUS);
  assign rd_count = dsp_rd && (dsp_addr == `OFS_STAT_COUNT_VALUE);

  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      line_clock_pin_three_ctrl_r <= `RST_LINE_CLOCK3;
      pin_share_r <= `RST_PIN_SHARING;
      status_two_r <= `RST_DSP_STATUS_TWO;
      irq_enable_bit_r <= `RST_IRQ_ENABLE;
      stat_limit_r <= `RST_STAT_LIMIT;
      host_cfg_r <= `RST_HOST_CONFIG;
    end
    else
    begin
      if (wr_line_clock_pin_three)
        line_clock_pin_three_ctrl_r <= dsp_wdata[`LCLK_OUT_EN_BIT:`LCLK_RATE_LSB];
      if (wr_share)
        pin_share_r <= dsp_wdata[`PCM13_REUSE_BIT:`BACKPLANE_REUSE_BIT];
      // only bits 9 and 8 are kept, the rest of the word is dropped
      if (dsp_status_two_wr)
        status_two_r <= dsp_status_two_wdata[`FRAME_RATE_SEL_BIT:`TABLE_WRITE_EN_BIT];
      if (wr_irq_en)
        irq_enable_bit_r <= dsp_wdata[`IRQ_ENABLE_BIT];
      if (wr_limit)
        stat_limit_r <= dsp_wdata[7:0];
      if (host_wr && (host_addr == `HOST_OFS_INTERFACE_CONFIG))
        host_cfg_r <= host_wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // frame events, set wins over the read clear

  always @*
  begin
    events_nxt = rd_events ? 3'h0 : events_r;
    if (pcm_fs_rise)
      events_nxt[`PCM_SYNC_BIT] = 1'b1;
    if (bp_fs_rise)
      events_nxt[`BACKPLANE_SYNC_BIT] = 1'b1;
    if (events_nxt[`PCM_SYNC_BIT] && events_nxt[`BACKPLANE_SYNC_BIT] && (pcm_fs_rise || bp_fs_rise))
      events_nxt[`BOTH_SYNC_BIT] = 1'b1;
  end

  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      events_r <= `RST_FRAME_EVENTS;
    else
      events_r <= events_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // statistics counter; no reset on purpose so a chip reset keeps the count

  always @*
  begin
    stat_count_nxt = stat_count_r;
    if (stat_event && (stat_count_r != stat_limit_r))
      stat_count_nxt = stat_count_r + 8'h01;
    if (bp_fs_rise && (stat_read_seen_r || rd_count))
      stat_count_nxt = 8'h00;
    if (wr_count)
      stat_count_nxt = dsp_wdata[7:0];
  end

  always @(posedge mclk)
  begin
    stat_count_r <= stat_count_nxt;
  end

  // a read in the same cycle as the sync counts toward that sync
  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
      stat_read_seen_r <= 1'b0;
    else if (bp_fs_rise)
      stat_read_seen_r <= 1'b0;
    else if (rd_count)
      stat_read_seen_r <= 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // mode strap caught on the first settled cycle after release

  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      mode_caught_r <= 1'b0;
      mode_wait_r <= 3'h0;
    end
    else if (mode_wait_r != `MODE_SETTLE_COUNT)
    begin
      // waits out the three synchroniser stages before trusting the level
      mode_wait_r <= mode_wait_r + 3'h1;
      mode_caught_r <= mode_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe

  always @*
  begin
    rdata_nxt = 16'h0000;
    case (dsp_addr)
      `OFS_CHANNEL_IRQ_ENABLE: rdata_nxt[`IRQ_ENABLE_BIT] = irq_enable_bit_r;
      `OFS_FRAME_EVENT_STATUS: rdata_nxt[2:0] = events_r;
      `OFS_STAT_COUNT_VALUE: rdata_nxt[7:0] = stat_count_r;
      `OFS_STAT_COUNT_LIMIT: rdata_nxt[7:0] = stat_limit_r;
      `OFS_PIN_SHARING_CONTROL: rdata_nxt[2:0] = pin_share_r;
      `OFS_HOST_INTERFACE_CONFIG: rdata_nxt = {7'h00, mode_caught_r, host_cfg_r};
      default: rdata_nxt = 16'h0000;
    endcase
  end

  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      dsp_rdata <= 16'h0000;
      host_rdata <= 8'h00;
    end
    else
    begin
      if (dsp_rd)
        dsp_rdata <= rdata_nxt;
      if (host_rd)
        host_rdata <= (host_addr == `HOST_OFS_INTERFACE_CONFIG) ? host_cfg_r : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // line clock three

  line_clock_nco u_nco (
    .clk(mclk),
    .rst_n(rst_n_r),
    .run(line_clock_pin_three_ctrl_r[`LCLK_OUT_EN_BIT]),
    .rate(line_clock_pin_three_ctrl_r[`LCLK_RATE_MSB:`LCLK_RATE_LSB]),
    .clk_out(nco_clk)
  );

  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      line_clock_pin_three_out <= 1'b0;
      line_clock_pin_three_oe_b <= 1'b1;
      line_clock_seen <= 1'b0;
    end
    else
    begin
      line_clock_pin_three_out <= nco_clk;
      line_clock_pin_three_oe_b <= !line_clock_pin_three_ctrl_r[`LCLK_OUT_EN_BIT];
      // as input the rate field is ignored and the pin clock is passed on
      line_clock_seen <= line_clock_pin_three_ctrl_r[`LCLK_OUT_EN_BIT] ? nco_clk : lclk_in_level;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // pin sharing, frame rate, scrambler tables and channel irq

  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      backplane_pin_reuse <= 1'b0;
      pcm02_pin_reuse <= 1'b0;
      pcm13_pin_reuse <= 1'b0;
      frame_rate_select <= 1'b0;
      table_write_enable <= 1'b0;
      table_wr_grant <= 3'h0;
      serial_irq_out <= 1'b0;
      stat_count_at_limit <= 1'b0;
    end
    else
    begin
      backplane_pin_reuse <= pin_share_r[`BACKPLANE_REUSE_BIT];
      pcm02_pin_reuse <= pin_share_r[`PCM02_REUSE_BIT];
      pcm13_pin_reuse <= pin_share_r[`PCM13_REUSE_BIT];
      frame_rate_select <= status_two_r[1];
      table_write_enable <= status_two_r[0];
      // test mode: only table 0 takes writes; software sequences the enable
      table_wr_grant[0] <= table_wr_req && (table_sel == 2'd0);
      table_wr_grant[1] <= table_wr_req && (table_sel == 2'd1) && status_two_r[0];
      table_wr_grant[2] <= table_wr_req && (table_sel == 2'd2) && status_two_r[0];
      serial_irq_out <= serial_irq_req && irq_enable_bit_r;
      stat_count_at_limit <= (stat_count_r == stat_limit_r);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////////
  // host interface pins

  assign irq_level = (host_irq_req && host_cfg_r[`CFG_IRQ_EN_BIT]) ~^ host_cfg_r[`CFG_IRQ_POL_BIT];

  always @(posedge mclk or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      dma_enable <= 1'b0;
      flyby_select <= 1'b0;
      peripheral_event_transfer <= 1'b0;
      host_interrupt_pin_out <= 1'b1;
      host_interrupt_pin_oe_b <= 1'b1;
      dma_request_pins <= 2'h0;
      ack_count_r <= 2'h0;
      vector_drive <= 1'b0;
    end
    else
    begin
      dma_enable <= host_cfg_r[`CFG_DMA_BIT];
      flyby_select <= host_cfg_r[`CFG_FLYBY_BIT];
      peripheral_event_transfer <= host_cfg_r[`CFG_PEC_BIT];
      host_interrupt_pin_out <= irq_level;
      // open drain pulls low only; push-pull drives both levels
      host_interrupt_pin_oe_b <= host_cfg_r[`CFG_IRQ_PUSHPULL_BIT] ? 1'b0 : irq_level;
      dma_request_pins[0] <= (dma_req_rx && host_cfg_r[`CFG_DMA_BIT])
        ^ host_cfg_r[`CFG_DRQ_POL_BIT];
      dma_request_pins[1] <= (dma_req_tx && host_cfg_r[`CFG_DMA_BIT])
        ^ host_cfg_r[`CFG_DRQ_POL_BIT];
      if (!host_irq_req)
        ack_count_r <= 2'h0;
      else if (ack_rise && (ack_count_r != 2'h2))
        ack_count_r <= ack_count_r + 2'h1;
      if (!ack_level)
        vector_drive <= 1'b0;
      else if (ack_rise && host_irq_req)
        vector_drive <= host_cfg_r[`CFG_ACK_MODE_BIT] ? (ack_count_r == 2'h1)
          : (ack_count_r == 2'h0);
    end
  end

endmodule // line_port_regs

// file: sim/line_port_monitor.sv
// concurrent checks on the line port register bank ports
// assumes single-cycle strobes and two-edge write latency
module line_port_monitor (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [15:0] dsp_addr,
  input wire logic dsp_wr,
  input wire logic dsp_rd,
  input wire logic [15:0] dsp_wdata,
  input wire logic [15:0] dsp_rdata,
  input wire logic dsp_status_two_wr,
  input wire logic [15:0] dsp_status_two_wdata,
  input wire logic [7:0] host_addr,
  input wire logic host_wr,
  input wire logic host_rd,
  input wire logic [7:0] host_wdata,
  input wire logic [7:0] host_rdata,
  input wire logic line_clock_pin_three_oe_b,
  input wire logic backplane_pin_reuse,
  input wire logic pcm02_pin_reuse,
  input wire logic pcm13_pin_reuse,
  input wire logic frame_rate_select,
  input wire logic table_write_enable,
  input wire logic table_wr_req,
  input wire logic [1:0] table_sel,
  input wire logic [2:0] table_wr_grant,
  input wire logic serial_irq_req,
  input wire logic serial_irq_out,
  input wire logic dma_enable,
  input wire logic flyby_select,
  input wire logic peripheral_event_transfer
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  ////////////////////////////////////////////////////////////////////////////////
  sequence dsp_wr_at(a);
    dsp_wr && dsp_addr == a;
  endsequence
  sequence dsp_rd_at(a);
    dsp_rd && dsp_addr == a;
  endsequence
  lclk_dir_a: assert property (dsp_wr_at(16'hd08d) |-> ##2
    line_clock_pin_three_oe_b == !$past(dsp_wdata[2], 2)) else $error("clock pin direction");
  pin_share_a: assert property (dsp_wr_at(16'hd14a) |-> ##2
    {pcm13_pin_reuse, pcm02_pin_reuse, backplane_pin_reuse} == $past(dsp_wdata[2:0], 2))
    else $error("pin sharing outputs");
  status_two_a: assert property (dsp_status_two_wr |-> ##2
    {frame_rate_select, table_write_enable} == $past(dsp_status_two_wdata[9:8], 2))
    else $error("status two outputs");
  test_grant_a: assert property (table_wr_req && !table_write_enable |=>
    table_wr_grant == ($past(table_sel) == 2'h0 ? 3'h1 : 3'h0)) else $error("test grant");
  full_grant_a: assert property (table_wr_req && table_write_enable && table_sel != 2'h3
    |=> table_wr_grant == 3'h1 << $past(table_sel)) else $error("full grant");
  irq_gate_a: assert property (!serial_irq_req |=> !serial_irq_out)
    else $error("irq without request");
  host_cfg_a: assert property (host_wr && host_addr == 8'h48 |-> ##2
    {peripheral_event_transfer, flyby_select, dma_enable} == $past(host_wdata[2:0], 2))
    else $error("host config outputs");
  wo_read_a: assert property (dsp_rd_at(16'hd08d) |=> dsp_rdata == 16'h0000)
    else $error("write-only read");
  limit_hi_a: assert property (dsp_rd_at(16'hd005) |=> dsp_rdata[15:8] == 8'h00)
    else $error("limit upper bits");
  host_miss_a: assert property (host_rd && host_addr != 8'h48 |=> host_rdata == 8'h00)
    else $error("host unmapped read");
endmodule // line_port_monitor

bind line_port_regs line_port_monitor line_port_monitor_i (.*);

// file: sim/bus_model.sv
// dsp core and host processor model: bus cycles and frame pins
// assumes callers issue one access at a time from one process
module bus_model (
  input wire logic mclk,
  output logic [15:0] dsp_addr,
  output logic dsp_wr,
  output logic dsp_rd,
  output logic [15:0] dsp_wdata,
  output logic dsp_status_two_wr,
  output logic [15:0] dsp_status_two_wdata,
  output logic [7:0] host_addr,
  output logic host_wr,
  output logic host_rd,
  output logic [7:0] host_wdata,
  output logic pcm_frame_sync_pin,
  output logic backplane_frame_sync_pin,
  output logic line_clock_pin_three_in,
  output logic mode_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    {dsp_addr, dsp_wr, dsp_rd, dsp_wdata, dsp_status_two_wr, dsp_status_two_wdata} = '0;
    {host_addr, host_wr, host_rd, host_wdata, pcm_frame_sync_pin} = '0;
    {backplane_frame_sync_pin, line_clock_pin_three_in} = '0;
    mode_pin = 1'b1;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // idle bus shows inverted values so stale data never reads as valid
  task automatic dcyc(input logic w, input logic [15:0] a, d);
    @(negedge mclk);
    {dsp_addr, dsp_wdata, dsp_wr, dsp_rd} = {a, d, w, !w};
    @(negedge mclk);
    {dsp_addr, dsp_wdata, dsp_wr, dsp_rd} = {~a, ~d, 2'b00};
  endtask
  task automatic hcyc(input logic w, input logic [7:0] a, d);
    @(negedge mclk);
    {host_addr, host_wdata, host_wr, host_rd} = {a, d, w, !w};
    @(negedge mclk);
    {host_addr, host_wdata, host_wr, host_rd} = {~a, ~d, 2'b00};
  endtask
  task automatic st2(input logic [15:0] d);
    @(negedge mclk);
    {dsp_status_two_wdata, dsp_status_two_wr} = {d, 1'b1};
    @(negedge mclk);
    {dsp_status_two_wdata, dsp_status_two_wr} = {~d, 1'b0};
  endtask
  // tables loaded with write enable off, enabled before scrambling starts
  task automatic table_load;
    st2(16'h0000);
    st2(16'h0100);
  endtask
  // held six cycles so the synchroniser filter accepts it
  task automatic pulse(input logic bp);
    @(negedge mclk);
    {backplane_frame_sync_pin, pcm_frame_sync_pin} = {bp, !bp};
    repeat (6) @(negedge mclk);
    {backplane_frame_sync_pin, pcm_frame_sync_pin} = 2'b00;
    repeat (8) @(negedge mclk);
  endtask
  task automatic lclk(input logic v);
    @(negedge mclk);
    line_clock_pin_three_in = v;
  endtask
endmodule // bus_model

// file: sim/line_port_ctrl_status_regs_bench.sv
// self-checking bench for the line port register bank
// assumes the bus model is the only source of register cycles
module line_port_ctrl_status_regs_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic mclk, rst_b, dsp_wr, dsp_rd, dsp_status_two_wr, host_wr, host_rd;
  logic [15:0] dsp_addr, dsp_wdata, dsp_rdata, dsp_status_two_wdata;
  logic [7:0] host_addr, host_wdata, host_rdata;
  logic line_clock_pin_three_in, line_clock_pin_three_out, line_clock_pin_three_oe_b;
  logic line_clock_seen, backplane_pin_reuse, pcm02_pin_reuse, pcm13_pin_reuse;
  logic frame_rate_select, table_write_enable, table_wr_req, serial_irq_req, serial_irq_out;
  logic [1:0] table_sel, dma_request_pins;
  logic [2:0] table_wr_grant;
  logic pcm_frame_sync_pin, backplane_frame_sync_pin, stat_event, stat_count_at_limit;
  logic dma_enable, flyby_select, peripheral_event_transfer, interrupt_ack_pin, vector_drive;
  logic host_irq_req, host_interrupt_pin_out, host_interrupt_pin_oe_b, dma_req_rx, dma_req_tx;
  logic mode_pin, lvl;
  logic d_pend = 1'b0;
  logic h_pend = 1'b0;
  logic [15:0] exp_d[$], exp_h[$], v;
  logic [7:0] c;
  int seed;
  int err_count = 0, compares = 0, cycles = 0, edges = 0, i, k, e;
  logic [15:0] ra[6] = '{16'hd002, 16'hd003, 16'hd005, 16'hd08d, 16'hd14a, 16'hd006};
  logic [15:0] wa[4] = '{16'hd002, 16'hd004, 16'hd005, 16'hd14a};
  logic [15:0] wm[4] = '{16'h0001, 16'h00ff, 16'h00ff, 16'h0007};
  line_port_regs line_port_regs_i (.*);
  bus_model bus_model_i (.*);
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("compares=%0d mismatches=%0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic rd(input logic [15:0] a, x);
    exp_d.push_back(x);
    bus_model_i.dcyc(1'b0, a, 16'h0000);
  endtask
  task automatic hrd(input logic [7:0] a, input logic [15:0] x);
    exp_h.push_back(x);
    bus_model_i.hcyc(1'b0, a, 8'h00);
  endtask
  task automatic ev(input int n);
    repeat (n)
    begin
      @(negedge mclk);
      stat_event = 1'b1;
      @(negedge mclk);
      stat_event = 1'b0;
    end
  endtask
  // read data lands on the edge that takes the strobe
  always @(posedge mclk)
  begin
    d_pend <= dsp_rd;
    h_pend <= host_rd;
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      err_count++;
      test_done;
    end
  end
  always @(negedge mclk)
  begin
    if (d_pend)
      check(dsp_rdata, exp_d.pop_front());
    if (h_pend)
      check({8'h00, host_rdata}, exp_h.pop_front());
  end
  always @(posedge line_clock_pin_three_out)
    edges++;
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    seed = 32'hf837;
    {rst_b, table_wr_req, table_sel, serial_irq_req, stat_event} = '0;
    {interrupt_ack_pin, host_irq_req, dma_req_rx, dma_req_tx} = '0;
    cyc(20);
    rst_b = 1'b1;
    cyc(3);
    for (i = 0; i < 6; i++)
      rd(ra[i], 16'h0000);
    rd(16'hd148, 16'h0100);
    hrd(8'h48, 16'h0000);
    hrd(8'h40, 16'h0000);
    for (i = 0; i < 4; i++)
    begin
      v = $random(seed);
      bus_model_i.dcyc(1'b1, wa[i], v);
      rd(wa[i], v & wm[i]);
    end
    for (k = 0; k < 8; k++)
    begin
      bus_model_i.dcyc(1'b1, 16'hd14a, k[15:0]);
      cyc(2);
      check({13'h0, pcm13_pin_reuse, pcm02_pin_reuse, backplane_pin_reuse}, k[15:0]);
    end
    for (k = 0; k < 4; k++)
    begin
      v = $random(seed);
      v[9:8] = k[1:0];
      bus_model_i.st2(v);
      cyc(2);
      check({14'h0, frame_rate_select, table_write_enable}, k[15:0]);
      table_wr_req = 1'b1;
      for (i = 0; i < 3; i++)
      begin
        table_sel = i[1:0];
        cyc(1);
        check({13'h0, table_wr_grant}, k[0] ? 16'h1 << i : {15'h0, i == 0});
      end
      table_wr_req = 1'b0;
    end
    bus_model_i.table_load;
    cyc(2);
    check({15'h0, table_write_enable}, 16'h0001);
    serial_irq_req = 1'b1;
    for (k = 0; k < 2; k++)
    begin
      bus_model_i.dcyc(1'b1, 16'hd002, k[15:0]);
      cyc(3);
      check({15'h0, serial_irq_out}, k[15:0]);
    end
    bus_model_i.pulse(1'b0);
    rd(16'hd003, 16'h0004);
    rd(16'hd003, 16'h0000);
    bus_model_i.pulse(1'b1);
    rd(16'hd003, 16'h0002);
    bus_model_i.pulse(1'b1);
    bus_model_i.pulse(1'b0);
    rd(16'hd003, 16'h0007);
    rd(16'hd003, 16'h0000);
    bus_model_i.dcyc(1'b1, 16'hd005, 16'h00ff);
    bus_model_i.dcyc(1'b1, 16'hd004, 16'h0000);
    ev(3);
    rd(16'hd004, 16'h0003);
    bus_model_i.pulse(1'b1);
    ev(2);
    bus_model_i.pulse(1'b1);
    rd(16'hd004, 16'h0002);
    bus_model_i.dcyc(1'b1, 16'hd005, 16'h0004);
    bus_model_i.dcyc(1'b1, 16'hd004, 16'h0000);
    ev(6);
    rd(16'hd004, 16'h0004);
    check({15'h0, stat_count_at_limit}, 16'h0001);
    // mid-run reset: the count survives, limit and host config return to zero
    rst_b = 1'b0;
    cyc(3);
    rst_b = 1'b1;
    cyc(8);
    rd(16'hd004, 16'h0004);
    rd(16'hd005, 16'h0000);
    rd(16'hd148, 16'h0100);
    host_irq_req = 1'b1;
    dma_req_rx = 1'b1;
    for (i = 0; i < 6; i++)
    begin
      c = $random(seed);
      bus_model_i.hcyc(1'b1, 8'h48, c);
      cyc(4);
      lvl = c[4] ? c[6] : !c[6];
      check({11'h0, dma_request_pins, peripheral_event_transfer, flyby_select, dma_enable},
        {11'h0, c[7], c[0] ^ c[7], c[2:0]});
      check({14'h0, host_interrupt_pin_oe_b, !host_interrupt_pin_oe_b & host_interrupt_pin_out},
        {14'h0, !c[5] & lvl, c[5] & lvl});
      hrd(8'h48, {8'h00, c});
      rd(16'hd148, {8'h01, c});
    end
    // two ack pulses per mode; the vector follows the first or the second
    for (k = 0; k < 2; k++)
    begin
      bus_model_i.hcyc(1'b1, 8'h48, {4'h0, k[0], 3'h0});
      host_irq_req = 1'b0;
      cyc(2);
      host_irq_req = 1'b1;
      for (i = 0; i < 2; i++)
      begin
        interrupt_ack_pin = 1'b1;
        cyc(7);
        check({15'h0, vector_drive}, {15'h0, k[0] == i[0]});
        interrupt_ack_pin = 1'b0;
        cyc(7);
      end
    end
    for (k = 0; k < 4; k++)
    begin
      bus_model_i.dcyc(1'b1, 16'hd08d, 16'h0004 | k[15:0]);
      cyc(10);
      edges = 0;
      cyc(2000);
      e = (2000 * 2048 << k) / 200000;
      check({15'h0, edges >= e && edges <= e + 1}, 16'h0001);
      check({15'h0, line_clock_pin_three_oe_b}, 16'h0000);
    end
    bus_model_i.dcyc(1'b1, 16'hd08d, 16'h0003);
    for (k = 1; k >= 0; k--)
    begin
      bus_model_i.lclk(k[0]);
      cyc(8);
      check({14'h0, line_clock_pin_three_oe_b, line_clock_seen},
        {14'h0, 1'b1, k[0]});
    end
    test_done;
  end
endmodule // line_port_ctrl_status_regs_bench
